// ==== rtl/power_state_pkg.sv ====
// Package of constants and types for the host power state manager.
// Overview of operation
// - Boot timer of five minutes removes host power if boot never confirmed.
// - Touch acts only after a continuous press-and-hold delay; brief touch ignored.
// - Indicator brightness ramps up while the pad is held during the delay.
// - Touch requests other than the long-hold force off are ignored while booting or shutting down.
// - Indicator pulses slowly in a boot or shutdown transition whenever no refusal flash is playing.
// - Touch during a transition plays a quick flashing refusal pattern.
// - On exhausted battery without supply, request shutdown, cut power when done.
// - Supply return while on battery keeps host powered.
// - Auto boot on supply return only when the restart setting is enabled.
// - Touch turn-on with depleted battery is refused with flashing, host stays off.
// - Touch turn-on refused with flashing when host already powered elsewhere.
// - Holding the pad about ten seconds forces host power off unconditionally.
package power_state_pkg;

  // Clock rate and times in their own units.
  localparam int unsigned ClkHz        = 25000000;
  localparam int unsigned BootTimeoutS = 300;
  localparam int unsigned ForceOffS    = 10;
  localparam int unsigned HoldMs       = 2000;
  localparam int unsigned FlashMs      = 800;
  localparam int unsigned TickHz       = 1000;

  // Cycles per millisecond tick; all long times count ticks.
  localparam int unsigned TickCycles   = ClkHz / TickHz;
  localparam int unsigned BootTicks    = BootTimeoutS * TickHz;
  localparam int unsigned ForceTicks   = ForceOffS * TickHz;
  localparam int unsigned HoldTicks    = HoldMs;
  localparam int unsigned FlashTicks   = FlashMs;

  localparam int unsigned TickW        = 16;
  localparam int unsigned CntW         = 20;
  localparam int unsigned PwmW         = 8;

  // Bits of the tick counter that choose the pulse and flash rates.
  localparam int unsigned PulseBit     = 10;
  localparam int unsigned FlashBit     = 6;

  typedef enum logic [2:0] {
    PwrOff,
    PwrBooting,
    PwrOn,
    PwrShutting
  } pwr_state_t;

endpackage : power_state_pkg

// ==== rtl/tick_divider.sv ====
// Divider that makes the one-cycle millisecond tick enable.
`timescale 1ns/10ps
module tick_divider
  import power_state_pkg::*;
#(
  parameter int unsigned TickLimit = TickCycles
) (
  input  wire logic mclk,
  input  wire logic srst,
  output logic      tick
);

  logic [TickW-1:0] cnt_q;
  wire              wrap = (cnt_q == TickW'(TickLimit - 1));

  // Counts clocks and pulses once per wrap.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick  <= wrap;
    end
  end

endmodule : tick_divider

// ==== rtl/host_power_state_manager.sv ====
// Power state sequencer for the host computer and its indicator light.
`timescale 1ns/10ps
module host_power_state_manager
  import power_state_pkg::*;
#(
  parameter int unsigned BootLimit  = BootTicks,
  parameter int unsigned ForceLimit = ForceTicks,
  parameter int unsigned HoldLimit  = HoldTicks,
  parameter int unsigned FlashLimit = FlashTicks,
  parameter int unsigned TickLimit  = TickCycles
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic touchPad,
  input  wire logic bootDone,
  input  wire logic hostHalted,
  input  wire logic supplyPresent,
  input  wire logic batteryDepleted,
  input  wire logic hostPoweredElsewhere,
  input  wire logic autoBootEnable,
  output logic      hostPowerEn,
  output logic      shutdownReq,
  output logic      power_indicator_light,
  output logic      busy
);

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick.
  logic tick;

  tick_divider #(
    .TickLimit (TickLimit)
  ) uDiv (
    .mclk (mclk),
    .srst (srst),
    .tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // State and counters.
  pwr_state_t      state_q, state_d;
  logic [CntW-1:0] holdCnt_q;
  logic [CntW-1:0] bootCnt_q;
  logic [CntW-1:0] flashCnt_q;
  logic [CntW-1:0] blinkCnt_q;
  logic [PwmW-1:0] pwm_q;
  logic            holdUsed_q;
  logic            supplyPrev_q;

  // Decoded conditions.
  wire inTransit   = (state_q == PwrBooting) || (state_q == PwrShutting);
  wire steady      = (state_q == PwrOff) || (state_q == PwrOn);
  wire holdReached = (holdCnt_q == CntW'(HoldLimit));
  wire holdFire    = tick && touchPad && !holdUsed_q &&
                     (holdCnt_q == CntW'(HoldLimit - 1));
  wire forceFire   = tick && touchPad &&
                     (holdCnt_q == CntW'(ForceLimit - 1));
  wire bootExpire  = tick && (bootCnt_q == CntW'(BootLimit - 1));
  wire supplyRise  = supplyPresent && !supplyPrev_q;
  wire onRefused   = batteryDepleted || hostPoweredElsewhere;
  wire touchRise   = touchPad && (holdCnt_q == '0);
  wire refuseTouch = (inTransit && touchRise) ||
                     (holdFire && state_q == PwrOff && onRefused);
  wire batExhaust  = !supplyPresent && batteryDepleted;

  ////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PwrOff: begin
        if (holdFire && !onRefused) begin
          state_d = PwrBooting;
        end else if (supplyRise && autoBootEnable && !onRefused) begin
          state_d = PwrBooting;
        end
      end
      PwrBooting: begin
        if (bootDone) begin
          state_d = PwrOn;
        end else if (bootExpire) begin
          state_d = PwrOff;
        end
      end
      PwrOn: begin
        if (holdFire || batExhaust) begin
          state_d = PwrShutting;
        end
      end
      PwrShutting: begin
        if (hostHalted) begin
          state_d = PwrOff;
        end
      end
      default: state_d = PwrOff;
    endcase
    if (forceFire) begin
      state_d = PwrOff;
    end
  end

  // State register and previous supply level.
  always_ff @(posedge mclk) begin
    if (srst) begin
      // Starts high so reset makes no false supply return.
      state_q      <= PwrOff;
      supplyPrev_q <= 1'b1;
    end else begin
      state_q      <= state_d;
      supplyPrev_q <= supplyPresent;
    end
  end

  // Hold counter runs while touched; one hold-delay state change per hold, besides force off.
  always_ff @(posedge mclk) begin
    if (srst || !touchPad) begin
      holdCnt_q  <= '0;
      holdUsed_q <= 1'b0;
    end else if (tick && holdCnt_q != CntW'(ForceLimit)) begin
      holdCnt_q  <= holdCnt_q + 1'b1;
      if (holdFire || (inTransit && holdReached)) begin
        holdUsed_q <= 1'b1;
      end
    end
  end

  // Boot timer restarts on entry to booting.
  always_ff @(posedge mclk) begin
    if (srst || state_q != PwrBooting) begin
      bootCnt_q <= '0;
    end else if (tick) begin
      bootCnt_q <= bootCnt_q + 1'b1;
    end
  end

  // Refusal flash counter loads on any refused touch.
  always_ff @(posedge mclk) begin
    if (srst) begin
      flashCnt_q <= '0;
    end else if (refuseTouch) begin
      flashCnt_q <= CntW'(FlashLimit);
    end else if (tick && flashCnt_q != '0) begin
      flashCnt_q <= flashCnt_q - 1'b1;
    end
  end

  // Free running counters for pulse and ramp PWM.
  always_ff @(posedge mclk) begin
    if (srst) begin
      blinkCnt_q <= '0;
      pwm_q      <= '0;
    end else begin
      pwm_q <= pwm_q + 1'b1;
      if (tick) begin
        blinkCnt_q <= blinkCnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicator pattern selection.
  wire [PwmW-1:0] ramp     = holdCnt_q[CntW-1:0] >= CntW'(HoldLimit) ?
                             {PwmW{1'b1}} :
                             PwmW'((holdCnt_q << PwmW) / CntW'(HoldLimit));
  wire [PwmW-1:0] pulseLvl = blinkCnt_q[PulseBit] ?
                             ~blinkCnt_q[PulseBit-1 -: PwmW] :
                             blinkCnt_q[PulseBit-1 -: PwmW];
  wire            flashing = (flashCnt_q != '0);
  wire            ledNext  =
    flashing               ? blinkCnt_q[FlashBit] :
    inTransit              ? (pwm_q < pulseLvl) :
    (touchPad && steady && !holdUsed_q) ? (pwm_q < ramp) :
    (state_q == PwrOn);

  // Registered outputs.
  always_ff @(posedge mclk) begin
    if (srst) begin
      hostPowerEn           <= 1'b0;
      shutdownReq           <= 1'b0;
      power_indicator_light <= 1'b0;
      busy                  <= 1'b0;
    end else begin
      // Power stays on across supply changes while not off.
      hostPowerEn           <= (state_d != PwrOff);
      shutdownReq           <= (state_d == PwrShutting);
      power_indicator_light <= ledNext;
      busy                  <= (state_d == PwrBooting) ||
                               (state_d == PwrShutting);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  boot_timeout_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrBooting && !bootDone && bootExpire && !forceFire)
    |=> state_q == PwrOff ##1 !hostPowerEn)
    else $error("Boot timeout did not remove power.");

  brief_touch_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrOff && $rose(touchPad)) ##1 !touchPad
    |=> state_q == PwrOff)
    else $error("Brief touch changed state.");

  transit_ignore_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrShutting && !hostHalted && !forceFire) |=> state_q != PwrOn)
    else $error("Touch acted during transition.");

  refuse_flash_a: assert property (@(posedge mclk) disable iff (srst)
    refuseTouch |=> flashCnt_q == CntW'(FlashLimit))
    else $error("Refusal flash not started.");

  bat_shutdown_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrOn && batExhaust && !forceFire) |=> shutdownReq)
    else $error("No shutdown request on exhausted battery.");

  halt_wait_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrShutting && !hostHalted && !forceFire) |=> hostPowerEn)
    else $error("Power removed before host halted.");

  supply_keep_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrOn && supplyRise && !forceFire && !holdFire)
    |=> hostPowerEn)
    else $error("Supply return interrupted host power.");

  depleted_off_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrOff && onRefused && !supplyRise) |=> state_q == PwrOff)
    else $error("Host turned on while refused.");

  force_off_a: assert property (@(posedge mclk) disable iff (srst)
    forceFire |=> !hostPowerEn)
    else $error("Long hold did not force power off.");

  boot_done_a: assert property (@(posedge mclk) disable iff (srst)
    (state_q == PwrBooting && bootDone && !forceFire)
    |=> !busy && hostPowerEn)
    else $error("Boot completion not accepted.");

endmodule : host_power_state_manager

// ==== dv/host_model.sv ====
// Behavioural host computer that confirms boot and finishes shutdown.
`timescale 1ns/10ps
module host_model (
  input  wire logic mclk,
  input  wire logic hostPowerEn,
  input  wire logic shutdownReq,
  input  wire logic answerBoot,
  input  wire logic answerHalt,
  output logic      bootDone = 1'b0,
  output logic      hostHalted = 1'b0
);
  logic [3:0] waitQ = 4'h0;

  // The host needs a few cycles after power-up before it can answer.
  always @(posedge mclk) begin
    if (!hostPowerEn) begin
      waitQ      <= 4'h0;
      bootDone   <= 1'b0;
      hostHalted <= 1'b0;
    end else if (waitQ != 4'h8) begin
      waitQ <= waitQ + 4'h1;
    end else begin
      bootDone   <= answerBoot && !shutdownReq;
      hostHalted <= answerHalt && shutdownReq;
    end
  end
endmodule : host_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the host power state manager.
`timescale 1ns/10ps
module tb_top;
  import power_state_pkg::*;
  localparam int Boot  = 20;
  localparam int Hold  = 4;
  localparam int Force = 12;
  localparam int Tick  = 50;
  logic mclk        = 1'b0;
  logic srst        = 1'b1;
  logic touchPad    = 1'b0;
  logic supply      = 1'b1;
  logic depleted    = 1'b0;
  logic elsewhere   = 1'b0;
  logic autoBoot    = 1'b0;
  logic answerBoot  = 1'b1;
  logic answerHalt  = 1'b1;
  logic bootDone;
  logic hostHalted;
  logic pow;
  logic req;
  logic light;
  logic busy;
  int   failures    = 0;
  int   num_checks  = 0;

  host_power_state_manager #(.BootLimit(Boot), .ForceLimit(Force),
    .HoldLimit(Hold), .FlashLimit(3), .TickLimit(Tick))
    dut_u (.mclk(mclk), .srst(srst),
    .touchPad(touchPad), .bootDone(bootDone), .hostHalted(hostHalted),
    .supplyPresent(supply), .batteryDepleted(depleted),
    .hostPoweredElsewhere(elsewhere), .autoBootEnable(autoBoot),
    .hostPowerEn(pow), .shutdownReq(req), .power_indicator_light(light),
    .busy(busy));
  host_model model_u (.mclk(mclk), .hostPowerEn(pow), .shutdownReq(req),
    .answerBoot(answerBoot), .answerHalt(answerHalt), .bootDone(bootDone),
    .hostHalted(hostHalted));

  // Free-running clock of 40 ns.
  always #20 mclk = ~mclk;

  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : check_bit

  // Waits whole ticks, then samples on the falling edge.
  task automatic ticks(input int n);
    repeat (n * Tick) @(posedge mclk);
    @(negedge mclk);
  endtask : ticks

  // Bounded wait for the host power switch to reach a level.
  task automatic wait_pow(input logic val, input int n);
    for (int i = 0; i < n * Tick && pow !== val; i++) @(negedge mclk);
    if (pow !== val) begin
      failures++;
      tally_and_finish();
    end
  endtask : wait_pow

  task automatic press(input int n);
    @(posedge mclk);
    touchPad <= 1'b1;
    ticks(n);
    @(posedge mclk);
    touchPad <= 1'b0;
    @(negedge mclk);
  endtask : press

  task automatic s_brief();
    press(Hold - 2);
    check_bit(pow, 1'b0, "brief touch powered host");
  endtask : s_brief

  task automatic s_boot_busy();
    @(posedge mclk);
    answerBoot <= 1'b0;
    press(Hold + 1);
    check_bit(pow, 1'b1, "hold did not power host");
    check_bit(busy, 1'b1, "not busy while booting");
    press(Hold + 1);
    check_bit(busy, 1'b1, "touch acted while booting");
    check_bit(req, 1'b0, "shutdown during boot");
    @(posedge mclk);
    answerBoot <= 1'b1;
    ticks(1);
    check_bit(busy, 1'b0, "boot report not taken");
    check_bit(pow, 1'b1, "power lost after boot");
    check_bit(light, 1'b1, "light not steady in on state");
  endtask : s_boot_busy

  task automatic s_touch_off();
    @(posedge mclk);
    answerHalt <= 1'b0;
    press(Hold + 1);
    check_bit(req, 1'b1, "no shutdown request");
    check_bit(busy, 1'b1, "not busy while shutting");
    check_bit(pow, 1'b1, "power cut before halt");
    @(posedge mclk);
    answerHalt <= 1'b1;
    wait_pow(1'b0, 1);
  endtask : s_touch_off

  task automatic s_refusals();
    @(posedge mclk);
    elsewhere <= 1'b1;
    press(Hold + 1);
    check_bit(pow, 1'b0, "on while fed elsewhere");
    @(posedge mclk);
    elsewhere <= 1'b0;
    answerBoot <= 1'b0;
    press(Hold + 1);
    ticks(Boot - 4);
    check_bit(pow, 1'b1, "boot timer too short");
    ticks(4);
    check_bit(pow, 1'b0, "boot timer never expired");
    @(posedge mclk);
    answerBoot <= 1'b1;
  endtask : s_refusals

  task automatic s_battery();
    press(Hold + 1);
    @(posedge mclk);
    supply <= 1'b0;
    ticks(1);
    @(posedge mclk);
    supply <= 1'b1;
    ticks(1);
    check_bit(pow, 1'b1, "power lost on supply return");
    @(posedge mclk);
    answerHalt <= 1'b0;
    supply <= 1'b0;
    depleted <= 1'b1;
    ticks(1);
    check_bit(req, 1'b1, "no shutdown on depletion");
    check_bit(pow, 1'b1, "power cut before halt");
    @(posedge mclk);
    answerHalt <= 1'b1;
    wait_pow(1'b0, 1);
    press(Hold + 1);
    check_bit(pow, 1'b0, "on with depleted battery");
    @(posedge mclk);
    depleted <= 1'b0;
    supply <= 1'b1;
    ticks(1);
    check_bit(pow, 1'b0, "auto boot by default");
    @(posedge mclk);
    autoBoot <= 1'b1;
    supply <= 1'b0;
    ticks(1);
    @(posedge mclk);
    supply <= 1'b1;
    wait_pow(1'b1, 1);
    ticks(1);
    @(posedge mclk);
    autoBoot <= 1'b0;
  endtask : s_battery

  task automatic s_force();
    @(posedge mclk);
    answerHalt <= 1'b0;
    press(Force + 1);
    check_bit(pow, 1'b0, "long hold did not force off");
    check_bit(light, 1'b0, "light lit after forced off");
  endtask : s_force

  // Reset for two cycles, then run every scenario in turn.
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    check_bit(pow, 1'b0, "power on after reset");
    s_brief();
    s_boot_busy();
    s_touch_off();
    s_refusals();
    s_battery();
    s_force();
    tally_and_finish();
  end
endmodule : tb_top
